// ===== src/rtcc_clock.sv
// Overview of operation
// - Freeze bit stops counter-to-holding copies while it stays set.
// - While halted the holding registers keep the time current at the halt.
// - Halting copies never stops or disturbs the running time counters.
// - All time and calendar holding registers are copied in one single step.
// - A halt arriving during a copy lets that copy finish first.
// - After the freeze bit clears, copies resume within one second.
// - Setting the load bit halts copies so the host can write the time.
// - Clearing the load bit copies holding registers into the counters.
// - Calibration adds or removes counts at the divide-by-32768 seconds counter stage only.
// - Calibration magnitude is 0..31 in the five low control bits.
// - Control bit five picks sign: one runs faster, zero runs slower.
// - Over 64 minutes, one second per minute changes by 128 cycles.
// - Value N changes only the first 2N minutes of each cycle.
// - With test bit set and freeze bit clear, seconds register bit zero toggles at 512 Hz.
// - Calibration value never changes the test toggle frequency.
// - Top to bottom: year, month, date, day, hour, minutes, seconds, control.
// - Date rolls over correctly for all month lengths and leap years.
// - Writing one to the stop bit stops the oscillator, zero restarts it.
`timescale 1ns/1ns
module rtcc_clock #(
    parameter int CLK_PER_OSC = rtcc_pkg::CLK_PER_OSC
) (
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic [10:0] addr,
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic [7:0]  data_in,
    output logic      [7:0]  data_out,
    output logic             data_oe
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    generate
        if (CLK_PER_OSC < 2 || CLK_PER_OSC > 65535) begin : g_bad_div
            $error("CLK_PER_OSC must lie in 2..65535");
        end
    endgenerate

    localparam logic [15:0] DIV_LAST = 16'(CLK_PER_OSC - 1);
    localparam logic [15:0] LEN_NOM  = 16'(rtcc_pkg::SEC_TICKS);
    localparam logic [15:0] LEN_FAST = 16'(rtcc_pkg::SEC_TICKS
                                           - rtcc_pkg::CAL_TICKS);
    localparam logic [15:0] LEN_SLOW = 16'(rtcc_pkg::SEC_TICKS
                                           + rtcc_pkg::CAL_TICKS);
    localparam logic [4:0]  FT_LAST  = 5'(rtcc_pkg::TEST_HALF - 1);

    rtcc_time_if tif ();

    rtcc_calendar u_calendar (
        .clock (clock),
        .srst  (srst),
        .tif   (tif)
    );

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic [7:0]  hold_q [8];
    logic [7:0]  fresh [8];
    logic        wr_act_q;
    logic        wr_hit_q;
    logic [2:0]  wr_idx_q;
    logic [7:0]  wr_data_q;
    logic        wr_act;
    logic        wr_go;
    logic        in_range;
    logic        rd_act;
    logic [2:0]  rd_idx;
    logic [7:0]  rd_val;
    logic [7:0]  ctl;
    logic        halt;
    logic        load_go;
    logic        ld_q;
    logic        upd_q;
    logic        stop;
    logic        test_on;

    assign in_range = addr[10:3] == rtcc_pkg::ADDR_CTL[10:3];
    assign wr_act   = !ce_n && !we_n;
    assign wr_go    = wr_act_q && !wr_act;
    assign rd_act   = !ce_n && !oe_n && we_n && in_range;
    assign rd_idx   = addr[2:0];
    assign ctl      = hold_q[0];
    assign halt     = ctl[rtcc_pkg::CTL_LOAD_BIT]
                   || ctl[rtcc_pkg::CTL_FREEZE_BIT];
    assign load_go  = wr_go && wr_hit_q && wr_idx_q == 3'h0
                   && ctl[rtcc_pkg::CTL_LOAD_BIT]
                   && !wr_data_q[rtcc_pkg::CTL_LOAD_BIT];
    assign stop     = hold_q[1][rtcc_pkg::SEC_STOP_BIT];
    assign test_on  = hold_q[4][rtcc_pkg::WDAY_TEST_BIT]
                   && !ctl[rtcc_pkg::CTL_FREEZE_BIT];

    // The write lands when the strobe ends, as a memory cell would.
    always_ff @(posedge clock) begin
        if (srst) begin
            wr_act_q  <= 1'b0;
            wr_hit_q  <= 1'b0;
            wr_idx_q  <= 3'h0;
            wr_data_q <= 8'h00;
        end else begin
            wr_act_q <= wr_act;
            if (wr_act) begin
                wr_hit_q  <= in_range;
                wr_idx_q  <= addr[2:0];
                wr_data_q <= data_in;
            end
        end
    end

    // ------------------------------------------------------------
    // Oscillator, calibrated second and test toggle
    // ------------------------------------------------------------
    logic [15:0] osc_div_q;
    logic [15:0] sec_cnt_q;
    logic [15:0] sec_len;
    logic [5:0]  min_cyc_q;
    logic [4:0]  ft_cnt_q;
    logic        ft_bit_q;
    logic        osc_tick;
    logic        cal_sec;
    logic        sec_end;

    assign osc_tick = !stop && osc_div_q == DIV_LAST;
    assign cal_sec  = tif.now[rtcc_pkg::T_SEC] == 8'h00
                   && min_cyc_q < {ctl[rtcc_pkg::CAL_W-1:0], 1'b0};
    assign sec_len  = !cal_sec ? LEN_NOM
                    : ctl[rtcc_pkg::CTL_SIGN_BIT] ? LEN_FAST
                    : LEN_SLOW;
    assign sec_end  = osc_tick && sec_cnt_q >= sec_len - 16'h0001;

    always_ff @(posedge clock) begin
        if (srst || osc_tick) begin
            osc_div_q <= 16'h0000;
        end else if (!stop) begin
            osc_div_q <= osc_div_q + 16'h0001;
        end
    end

    always_ff @(posedge clock) begin
        if (srst || ld_q || sec_end) begin
            sec_cnt_q <= 16'h0000;
        end else if (osc_tick) begin
            sec_cnt_q <= sec_cnt_q + 16'h0001;
        end
    end

    // Six bits wrap at 64 minutes on their own.
    always_ff @(posedge clock) begin
        if (srst) begin
            min_cyc_q <= 6'h00;
        end else if (tif.min_wrap) begin
            min_cyc_q <= min_cyc_q + 6'h01;
        end
    end

    // Taken before the calibrated stage so trimming cannot move it.
    always_ff @(posedge clock) begin
        if (srst) begin
            ft_cnt_q <= 5'h00;
            ft_bit_q <= 1'b0;
        end else if (osc_tick) begin
            ft_cnt_q <= ft_cnt_q + 5'h01;
            if (ft_cnt_q == FT_LAST) begin
                ft_bit_q <= !ft_bit_q;
            end
        end
    end

    // ------------------------------------------------------------
    // Snapshot and load control
    // ------------------------------------------------------------
    // The halt is sampled with the tick, so a copy once decided completes.
    always_ff @(posedge clock) begin
        if (srst) begin
            upd_q <= 1'b0;
            ld_q  <= 1'b0;
        end else begin
            upd_q <= sec_end && !halt;
            ld_q  <= load_go;
        end
    end

    assign tif.tick = sec_end;
    assign tif.load = ld_q;

    // ------------------------------------------------------------
    // Holding registers
    // ------------------------------------------------------------
    assign fresh[0] = hold_q[0];

    generate
        for (genvar i = 0; i < rtcc_pkg::N_REGS; i++) begin : g_hold
            if (i > 0) begin : g_time
                assign fresh[i] = (hold_q[i] & rtcc_pkg::HOST_BITS[i])
                               | (tif.now[i-1] & ~rtcc_pkg::HOST_BITS[i]);
                assign tif.load_val[i-1] = hold_q[i]
                                         & rtcc_pkg::VAL_MASK[i];
            end
            always_ff @(posedge clock) begin
                if (srst) begin
                    hold_q[i] <= rtcc_pkg::HOLD_RST[i];
                end else if (wr_go && wr_hit_q && wr_idx_q == 3'(i)) begin
                    hold_q[i] <= wr_data_q;
                end else if (upd_q) begin
                    hold_q[i] <= fresh[i];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    assign rd_val = (rd_idx == 3'h1 && test_on)
                  ? {hold_q[1][7:1], ft_bit_q}
                  : hold_q[rd_idx];

    always_ff @(posedge clock) begin
        if (srst) begin
            data_out <= 8'h00;
            data_oe  <= 1'b0;
        end else begin
            data_out <= rd_act ? rd_val : 8'h00;
            data_oe  <= rd_act;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    localparam int STALE_MAX = (rtcc_pkg::SEC_TICKS + rtcc_pkg::CAL_TICKS)
                             * CLK_PER_OSC + 4;
    logic [31:0] stale_q;

    always_ff @(posedge clock) begin
        if (srst || halt || stop || upd_q || ld_q) begin
            stale_q <= 32'h0000_0000;
        end else begin
            stale_q <= stale_q + 32'h0000_0001;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    property p_freeze_blocks;
        halt |=> !upd_q;
    endproperty
    a_freeze_blocks : assert property (p_freeze_blocks)
        else $error("snapshot copy while halted");

    property p_freeze_stable;
        halt && $past(halt) && !wr_go |=> $stable(hold_q[1][6:0])
            && $stable(hold_q[2]) && $stable(hold_q[7]);
    endproperty
    a_freeze_stable : assert property (p_freeze_stable)
        else $error("holding time changed while halted");

    property p_counters_run;
        sec_end && !ld_q |=> tif.now != $past(tif.now);
    endproperty
    a_counters_run : assert property (p_counters_run)
        else $error("counters failed to advance on a second tick");

    property p_copy_all;
        upd_q && !wr_go |=> hold_q[1][6:0] == $past(tif.now[0][6:0])
            && hold_q[7] == $past(tif.now[6])
            && hold_q[5] == $past(tif.now[4]);
    endproperty
    a_copy_all : assert property (p_copy_all)
        else $error("snapshot did not copy every field");

    property p_resume;
        stale_q <= 32'(STALE_MAX);
    endproperty
    a_resume : assert property (p_resume)
        else $error("no snapshot within one second of resuming");

    property p_load_counters;
        ld_q |=> tif.now[0] == ($past(hold_q[1]) & rtcc_pkg::VAL_MASK[1]);
    endproperty
    a_load_counters : assert property (p_load_counters)
        else $error("counters not loaded from holding registers");

    property p_cal_window;
        cal_sec |-> min_cyc_q < 6'h3E && ctl[4:0] != 5'h00;
    endproperty
    a_cal_window : assert property (p_cal_window)
        else $error("calibration outside its minute window");

    property p_cal_length;
        sec_end && cal_sec && ctl[rtcc_pkg::CTL_SIGN_BIT]
            |-> sec_cnt_q == LEN_FAST - 16'h0001;
    endproperty
    a_cal_length : assert property (p_cal_length)
        else $error("fast calibrated second has wrong length");

    property p_stop_osc;
        stop && !ld_q |=> $stable(osc_div_q) && $stable(sec_cnt_q);
    endproperty
    a_stop_osc : assert property (p_stop_osc)
        else $error("oscillator ticked while stopped");

    property p_test_toggle;
        osc_tick && ft_cnt_q == FT_LAST |=> ft_bit_q != $past(ft_bit_q);
    endproperty
    a_test_toggle : assert property (p_test_toggle)
        else $error("test toggle missed its edge");

    c_load    : cover property (ld_q);
    c_cal     : cover property (sec_end && cal_sec);
    c_halt_up : cover property (upd_q && halt);
    c_read    : cover property (data_oe && test_on);

endmodule : rtcc_clock

// ===== include/rtcc_pkg.sv
package rtcc_pkg;

    // ------------------------------------------------------------
    // Bus geometry and register offsets
    // ------------------------------------------------------------
    localparam int          ADDR_W      = 11;
    localparam int          DATA_W      = 8;
    localparam int          N_REGS      = 8;
    localparam logic [10:0] ADDR_CTL    = 11'h7F8;
    localparam logic [10:0] ADDR_SEC    = 11'h7F9;
    localparam logic [10:0] ADDR_MIN    = 11'h7FA;
    localparam logic [10:0] ADDR_HOUR   = 11'h7FB;
    localparam logic [10:0] ADDR_WDAY   = 11'h7FC;
    localparam logic [10:0] ADDR_MDAY   = 11'h7FD;
    localparam logic [10:0] ADDR_MON    = 11'h7FE;
    localparam logic [10:0] ADDR_YEAR   = 11'h7FF;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTL_LOAD_BIT   = 7;
    localparam int CTL_FREEZE_BIT = 6;
    localparam int CTL_SIGN_BIT   = 5;
    localparam int CAL_W          = 5;
    localparam int SEC_STOP_BIT   = 7;
    localparam int HOUR_KICK_BIT  = 7;
    localparam int WDAY_TEST_BIT  = 6;

    // Index of each field in the time vector.
    localparam int T_SEC  = 0;
    localparam int T_MIN  = 1;
    localparam int T_HOUR = 2;
    localparam int T_WDAY = 3;
    localparam int T_MDAY = 4;
    localparam int T_MON  = 5;
    localparam int T_YEAR = 6;

    typedef logic [6:0][7:0] rtcc_time_t;
    typedef logic [7:0][7:0] rtcc_regs_t;

    // ------------------------------------------------------------
    // Masks and reset values, index 0 is the control register except in TIME_RST, where it is seconds
    // ------------------------------------------------------------
    localparam rtcc_regs_t HOST_BITS = {8'h00, 8'h00, 8'h00, 8'h40,
                                        8'h80, 8'h00, 8'h80, 8'h00};
    localparam rtcc_regs_t VAL_MASK  = {8'hFF, 8'h1F, 8'h3F, 8'h07,
                                        8'h3F, 8'h7F, 8'h7F, 8'hFF};
    localparam rtcc_time_t TIME_RST  = {8'h00, 8'h01, 8'h01, 8'h01,
                                        8'h00, 8'h00, 8'h00};
    localparam logic [7:0] CTL_RST   = 8'h00;
    localparam rtcc_regs_t HOLD_RST  = {TIME_RST, CTL_RST};

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ        = 25_000_000;
    localparam int OSC_HZ        = 32768;
    localparam int CLK_PER_OSC   = CLK_HZ / OSC_HZ;
    localparam int PRESCALE      = 256;
    localparam int CAL_TICKS     = PRESCALE / 2;
    localparam int SEC_TICKS     = OSC_HZ;
    localparam int CAL_CYCLE_MIN = 64;
    localparam int TEST_HZ       = 512;
    localparam int TEST_HALF     = OSC_HZ / (2 * TEST_HZ);

endpackage : rtcc_pkg

// ===== include/rtcc_time_if.sv
`timescale 1ns/1ns
interface rtcc_time_if;
    logic               tick;
    logic               load;
    rtcc_pkg::rtcc_time_t load_val;
    rtcc_pkg::rtcc_time_t now;
    logic               min_wrap;

    modport counter (input tick, input load, input load_val,
                     output now, output min_wrap);
    modport ctrl    (output tick, output load, output load_val,
                     input now, input min_wrap);
endinterface : rtcc_time_if

// ===== src/rtcc_calendar.sv
`timescale 1ns/1ns
module rtcc_calendar (
    input  wire logic     clock,
    input  wire logic     srst,
    rtcc_time_if.counter  tif
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] >= 4'h9) begin
            return {v[7:4] + 4'h1, 4'h0};
        end
        return v + 8'h01;
    endfunction : bcd_inc

    // Years are taken as 20yy, so 00 is a leap year.
    function automatic logic [7:0] month_len(input logic [7:0] mo,
                                             input logic [7:0] yr);
        logic [2:0] r;
        r = 3'({yr[4], 1'b0}) + 3'(yr[1:0]);
        case (mo)
            8'h02:                      return (r[1:0] == 2'h0) ? 8'h29
                                                                : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
            default:                    return 8'h31;
        endcase
    endfunction : month_len

    // ------------------------------------------------------------
    // Carry chain
    // ------------------------------------------------------------
    rtcc_pkg::rtcc_time_t now_q;
    rtcc_pkg::rtcc_time_t nxt;
    logic                 min_wrap_q;
    logic [7:0]           dim;
    logic                 c_s;
    logic                 c_m;
    logic                 c_h;
    logic                 c_d;
    logic                 c_mo;

    assign dim  = month_len(now_q[rtcc_pkg::T_MON], now_q[rtcc_pkg::T_YEAR]);
    assign c_s  = now_q[rtcc_pkg::T_SEC] >= 8'h59;
    assign c_m  = c_s && now_q[rtcc_pkg::T_MIN] >= 8'h59;
    assign c_h  = c_m && now_q[rtcc_pkg::T_HOUR] >= 8'h23;
    assign c_d  = c_h && now_q[rtcc_pkg::T_MDAY] >= dim;
    assign c_mo = c_d && now_q[rtcc_pkg::T_MON] >= 8'h12;

    always_comb begin
        nxt = now_q;
        nxt[rtcc_pkg::T_SEC] = c_s ? 8'h00
                                   : bcd_inc(now_q[rtcc_pkg::T_SEC]);
        if (c_s) begin
            nxt[rtcc_pkg::T_MIN] = c_m ? 8'h00
                                       : bcd_inc(now_q[rtcc_pkg::T_MIN]);
        end
        if (c_m) begin
            nxt[rtcc_pkg::T_HOUR] = c_h ? 8'h00
                                        : bcd_inc(now_q[rtcc_pkg::T_HOUR]);
        end
        if (c_h) begin
            nxt[rtcc_pkg::T_WDAY] = (now_q[rtcc_pkg::T_WDAY] >= 8'h07) ? 8'h01
                                  : bcd_inc(now_q[rtcc_pkg::T_WDAY]);
            nxt[rtcc_pkg::T_MDAY] = c_d ? 8'h01
                                        : bcd_inc(now_q[rtcc_pkg::T_MDAY]);
        end
        if (c_d) begin
            nxt[rtcc_pkg::T_MON] = c_mo ? 8'h01
                                        : bcd_inc(now_q[rtcc_pkg::T_MON]);
        end
        if (c_mo) begin
            nxt[rtcc_pkg::T_YEAR] = (now_q[rtcc_pkg::T_YEAR] >= 8'h99) ? 8'h00
                                  : bcd_inc(now_q[rtcc_pkg::T_YEAR]);
        end
    end

    // ------------------------------------------------------------
    // Counters
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            now_q <= rtcc_pkg::TIME_RST;
        end else if (tif.load) begin
            now_q <= tif.load_val;
        end else if (tif.tick) begin
            now_q <= nxt;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            min_wrap_q <= 1'b0;
        end else begin
            min_wrap_q <= tif.tick && !tif.load && c_s;
        end
    end

    assign tif.now      = now_q;
    assign tif.min_wrap = min_wrap_q;

endmodule : rtcc_calendar

// ===== dv/rtcc_host.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Host bus master model
// ------------------------------------------------------------
module rtcc_host (
    input  wire logic        clock,
    output logic      [10:0] addr,
    output logic             ce_n,
    output logic             oe_n,
    output logic             we_n,
    output logic      [7:0]  data_in
);
    initial begin
        addr    = 11'h000;
        ce_n    = 1'b1;
        oe_n    = 1'b1;
        we_n    = 1'b1;
        data_in = 8'h00;
    end

    // Released data never shows the last value, so no stale match.
    task automatic idle();
        ce_n    <= 1'b1;
        oe_n    <= 1'b1;
        we_n    <= 1'b1;
        data_in <= ~data_in;
    endtask : idle

    task automatic wr(input logic [10:0] a, input logic [7:0] d);
        @(posedge clock);
        addr    <= a;
        data_in <= d;
        ce_n    <= 1'b0;
        we_n    <= 1'b0;
        @(posedge clock);
        idle();
    endtask : wr

    // An extended read stays selected on one address until ended.
    task automatic rd_start(input logic [10:0] a);
        @(posedge clock);
        addr <= a;
        ce_n <= 1'b0;
        oe_n <= 1'b0;
    endtask : rd_start

    task automatic rd_end();
        @(posedge clock);
        idle();
    endtask : rd_end

    // Fixed-zero bits stay zero in every value the bench passes.
    task automatic set_time(input rtcc_pkg::rtcc_time_t t);
        wr(rtcc_pkg::ADDR_CTL, 8'h80);
        for (int i = 0; i < 7; i++) begin
            wr(rtcc_pkg::ADDR_SEC + 11'(i), t[i]);
        end
        wr(rtcc_pkg::ADDR_CTL, 8'h00);
    endtask : set_time
endmodule : rtcc_host

// ===== dv/rtcc_clock_tb.sv
`timescale 1ns/1ns
module rtcc_clock_tb;
    localparam int CPO = 2;
    localparam rtcc_pkg::rtcc_time_t LO = {8'h00, 8'h01, 8'h01, 8'h01,
                                           8'h00, 8'h00, 8'h00};
    localparam rtcc_pkg::rtcc_time_t HI = {8'h99, 8'h12, 8'h31, 8'h07,
                                           8'h23, 8'h59, 8'h59};
    logic        clock;
    logic        srst;
    logic [10:0] addr;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic [7:0]  data_in;
    logic [7:0]  data_out;
    logic        data_oe;
    int          failures;
    int          checks;
    int          n;
    logic [31:0] seed;
    logic [7:0]  c;
    logic        prev;

    rtcc_host rtcc_host_i (.clock(clock), .addr(addr), .ce_n(ce_n),
        .oe_n(oe_n), .we_n(we_n), .data_in(data_in));
    rtcc_clock #(.CLK_PER_OSC(CPO)) rtcc_clock_i (.clock(clock),
        .srst(srst), .addr(addr), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // Every field here sits at its limit, so each one wraps.
    function automatic logic [7:0] bcd_inc(input logic [7:0] v, lo, hi);
        if (v >= hi) return lo;
        if (v[3:0] == 4'h9) return {v[7:4] + 4'h1, 4'h0};
        return v + 8'h01;
    endfunction : bcd_inc

    task automatic bad(input string m);
        failures++;
        $display("BAD %0t %s", $time, m);
    endtask : bad

    task automatic rd(input logic [10:0] a, input logic [7:0] e,
                      input logic on);
        rtcc_host_i.rd_start(a);
        @(posedge clock);
        @(posedge clock);
        #1;
        checks++;
        if (data_oe !== on || (on && data_out !== e)) bad("read");
        rtcc_host_i.rd_end();
    endtask : rd

    task automatic tally_and_finish();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        failures = 0;
        checks   = 0;
        seed     = 32'h061223AD;
        srst     = 1'b1;
        repeat (3) @(posedge clock);
        srst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd(rtcc_pkg::ADDR_CTL + 11'(i),
               rtcc_pkg::HOLD_RST[i], 1'b1);
        end
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            rd({1'b0, seed[9:0]}, 8'h00, 1'b0);
            c = {2'b01, seed[5:0]};
            rtcc_host_i.wr(rtcc_pkg::ADDR_CTL, c);
            rd(rtcc_pkg::ADDR_CTL, c, 1'b1);
        end
        $display("test registers done");
        rtcc_host_i.set_time({rtcc_pkg::TIME_RST[6:4], 8'h41,
                              rtcc_pkg::TIME_RST[2:0]});
        rtcc_host_i.wr(rtcc_pkg::ADDR_CTL, 8'h1F);
        rtcc_host_i.rd_start(rtcc_pkg::ADDR_SEC);
        repeat (2) @(posedge clock);
        #1;
        prev = data_out[0];
        n = 0;
        repeat (640) begin
            @(posedge clock);
            #1;
            if (data_out[0] !== prev) n++;
            prev = data_out[0];
        end
        rtcc_host_i.rd_end();
        checks++;
        if (n < 9 || n > 11) bad("test toggle rate");
        $display("test toggle done");
        rtcc_host_i.set_time(HI);
        rd(rtcc_pkg::ADDR_SEC, 8'h59, 1'b1);
        repeat (32768 * CPO + 16) @(posedge clock);
        rtcc_host_i.wr(rtcc_pkg::ADDR_CTL, 8'h40);
        for (int i = 0; i < 7; i++) begin
            rd(rtcc_pkg::ADDR_SEC + 11'(i),
               bcd_inc(HI[i], LO[i], HI[i]), 1'b1);
        end
        $display("test rollover done");
        rtcc_host_i.wr(rtcc_pkg::ADDR_SEC, 8'h80);
        rd(rtcc_pkg::ADDR_SEC, 8'h80, 1'b1);
        rtcc_host_i.wr(rtcc_pkg::ADDR_CTL, 8'h80);
        rtcc_host_i.wr(rtcc_pkg::ADDR_SEC, 8'h00);
        rtcc_host_i.wr(rtcc_pkg::ADDR_HOUR, 8'h80);
        rtcc_host_i.wr(rtcc_pkg::ADDR_CTL, 8'h00);
        rd(rtcc_pkg::ADDR_HOUR, 8'h80, 1'b1);
        $display("test oscillator done");
        tally_and_finish();
    end

    // A hang is cut short well beyond the longest sequence.
    initial begin
        repeat (90000) @(posedge clock);
        bad("timeout");
        tally_and_finish();
    end
endmodule : rtcc_clock_tb
